// ==== inc/brt_pkg.sv ====
// shared constants, types and helpers for the block ram tile
package brt_pkg;

  localparam int unsigned ARRAY_BITS   = 9216; // 9 kbit, ninth bits included
  localparam int unsigned POW2_BITS    = 8192; // narrow shapes use only the low 8192 bits of the array
  localparam int unsigned ADDR_W       = 13;
  localparam int unsigned DATA_W       = 36;
  localparam int unsigned BASE_W       = 14;
  localparam int unsigned NARROW_MAX_W = 4;
  localparam int unsigned TDP_MAX_W    = 18;

  typedef enum logic [1:0] {
    BRT_SINGLE,
    BRT_TRUE_DUAL,
    BRT_PSEUDO_DUAL,
    BRT_FIFO
  } brt_mode_t;

  typedef struct packed {
    logic              en;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } brt_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } brt_rsp_t;

  typedef struct packed {
    logic full;
    logic empty;
  } brt_fifo_flags_t;

  function automatic int unsigned brt_depth(input int unsigned w);
    return (w <= NARROW_MAX_W) ? POW2_BITS / w : ARRAY_BITS / w;
  endfunction

  function automatic bit brt_width_ok(input int unsigned w);
    return w inside {1, 2, 4, 9, 18, 36};
  endfunction

endpackage

// ==== hw/brt_fifo_ctrl.sv ====
// pointer and flag keeping for the tile in buffer mode
`timescale 1ns/100ps
module brt_fifo_ctrl #(
  parameter int unsigned DEPTH = 1024
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         push_req,
  input  wire logic                         pop_req,
  output logic                              push_ok,
  output logic                              pop_ok,
  output logic [brt_pkg::ADDR_W-1:0]        wr_ptr,
  output logic [brt_pkg::ADDR_W-1:0]        rd_ptr,
  output brt_pkg::brt_fifo_flags_t          flags
);

  localparam int unsigned               CNT_W = brt_pkg::ADDR_W + 1;
  localparam logic [brt_pkg::ADDR_W-1:0] LAST  = brt_pkg::ADDR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0]          FULL_CNT = CNT_W'(DEPTH);

  logic [CNT_W-1:0]           count_reg;
  logic [CNT_W-1:0]           count_next;
  logic [brt_pkg::ADDR_W-1:0] wr_ptr_reg;
  logic [brt_pkg::ADDR_W-1:0] rd_ptr_reg;
  brt_pkg::brt_fifo_flags_t   flags_reg;

  ////////////////////////////////////////////////////////////////
  // acceptance: refused requests leave pointers and count alone
  assign push_ok    = push_req & ~flags_reg.full;
  assign pop_ok     = pop_req & ~flags_reg.empty;
  assign count_next = CNT_W'(count_reg + CNT_W'(push_ok) - CNT_W'(pop_ok));

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg  <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      flags_reg  <= '{full: 1'b0, empty: 1'b1};
    end else begin
      count_reg  <= count_next;
      if (push_ok) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      flags_reg.full  <= (count_next == FULL_CNT);
      flags_reg.empty <= (count_next == '0);
    end
  end

  assign wr_ptr = wr_ptr_reg;
  assign rd_ptr = rd_ptr_reg;
  assign flags  = flags_reg;

endmodule

// ==== hw/brt_block_ram_tile.sv ====
// configurable 9 kbit block ram tile: ram modes, buffer mode, rom by preload
`timescale 1ns/100ps
module brt_block_ram_tile #(
  parameter brt_pkg::brt_mode_t                MODE     = brt_pkg::BRT_SINGLE,
  parameter int unsigned                       WIDTH_A  = 9,
  parameter int unsigned                       WIDTH_B  = 9,
  parameter bit                                OUT_REG  = 1'b0,
  parameter logic [brt_pkg::ARRAY_BITS-1:0]    INIT     = '0
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire brt_pkg::brt_req_t   a_req,
  input  wire brt_pkg::brt_req_t   b_req,
  output brt_pkg::brt_rsp_t        a_rsp,
  output brt_pkg::brt_rsp_t        b_rsp,
  output brt_pkg::brt_fifo_flags_t fifo_flags
);

  localparam int unsigned DEPTH_A = brt_pkg::brt_depth(WIDTH_A);
  localparam int unsigned DEPTH_B = brt_pkg::brt_depth(WIDTH_B);
  localparam int unsigned NBITS   = brt_pkg::ARRAY_BITS;
  localparam int unsigned AW      = brt_pkg::ADDR_W;
  localparam int unsigned DW      = brt_pkg::DATA_W;
  localparam int unsigned BW      = brt_pkg::BASE_W;

  ////////////////////////////////////////////////////////////////
  // elaboration checks on the chosen shape
  if (!brt_pkg::brt_width_ok(WIDTH_A) || !brt_pkg::brt_width_ok(WIDTH_B)) begin : g_bad_width
    $error("port width is not one of 1, 2, 4, 9, 18, 36");
  end
  if (MODE == brt_pkg::BRT_TRUE_DUAL &&
      (WIDTH_A > brt_pkg::TDP_MAX_W || WIDTH_B > brt_pkg::TDP_MAX_W)) begin : g_bad_tdp
    $error("true dual-port mode has no 36 bit shape");
  end
  if (MODE == brt_pkg::BRT_FIFO && WIDTH_A != WIDTH_B) begin : g_bad_fifo
    $error("buffer mode needs equal widths on both ports");
  end

  ////////////////////////////////////////////////////////////////
  // mode decode
  wire is_fifo   = (MODE == brt_pkg::BRT_FIFO);
  wire is_pseudo = (MODE == brt_pkg::BRT_PSEUDO_DUAL);
  wire is_true   = (MODE == brt_pkg::BRT_TRUE_DUAL);
  wire b_active  = is_true | is_pseudo;

  // out-of-range addresses are dropped rather than aliased
  wire a_in_range = {1'b0, a_req.addr} < BW'(DEPTH_A);
  wire b_in_range = {1'b0, b_req.addr} < BW'(DEPTH_B);

  // buffer mode: port a pushes, port b pops
  wire              push_ok;
  wire              pop_ok;
  wire [AW-1:0]     wr_ptr;
  wire [AW-1:0]     rd_ptr;

  brt_fifo_ctrl #(
    .DEPTH (DEPTH_A)
  ) u_fifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .push_req (is_fifo & a_req.en & a_req.we),
    .pop_req  (is_fifo & b_req.en),
    .push_ok  (push_ok),
    .pop_ok   (pop_ok),
    .wr_ptr   (wr_ptr),
    .rd_ptr   (rd_ptr),
    .flags    (fifo_flags)
  );

  // effective per-port requests after mode steering
  wire a_en_ram = a_req.en & a_in_range & (~is_pseudo | a_req.we);
  wire a_en     = is_fifo ? push_ok : a_en_ram;
  wire a_we     = is_fifo | is_pseudo | a_req.we;
  wire [AW-1:0] a_addr = is_fifo ? wr_ptr : a_req.addr;

  wire b_en_ram = b_req.en & b_in_range & b_active;
  wire b_en     = is_fifo ? pop_ok : b_en_ram;
  wire b_we     = is_true & b_req.we;
  wire [AW-1:0] b_addr = is_fifo ? rd_ptr : b_req.addr;

  brt_pkg::brt_req_t eff [2];
  assign eff[0] = {a_en, a_we, a_addr, a_req.wdata};
  assign eff[1] = {b_en, b_we, b_addr, b_req.wdata};

  ////////////////////////////////////////////////////////////////
  // shared storage
  logic [NBITS-1:0] mem_reg;
  logic [NBITS-1:0] mem_step;
  logic [NBITS-1:0] mem_next;

  logic [1:0]       en_reg;
  logic [1:0]       we_reg;
  logic [AW-1:0]    addr_reg  [2];
  logic [DW-1:0]    wdata_reg [2];
  logic [BW-1:0]    base      [2];
  logic [NBITS-1:0] wmask     [2];
  logic [NBITS-1:0] wbits     [2];
  logic [DW-1:0]    rword     [2];
  logic [1:0]       wr_fire;
  brt_pkg::brt_rsp_t rsp_q    [2];

  ////////////////////////////////////////////////////////////////
  // per-port input capture, bit mapping and read pipeline
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int unsigned W = (p == 0) ? WIDTH_A : WIDTH_B;
    localparam logic [DW-1:0] LANE = {DW{1'b1}} >> (DW - W);

    brt_pkg::brt_rsp_t rd_reg;

    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        en_reg[p]    <= 1'b0;
        we_reg[p]    <= 1'b0;
        addr_reg[p]  <= '0;
        wdata_reg[p] <= '0;
      end else begin
        en_reg[p]    <= eff[p].en;
        we_reg[p]    <= eff[p].we;
        addr_reg[p]  <= eff[p].addr;
        wdata_reg[p] <= eff[p].wdata;
      end
    end

    // word n of width w starts at bit n*w, so both widths share one ordering
    assign base[p]    = BW'(addr_reg[p] * W);
    assign wmask[p]   = NBITS'(LANE) << base[p];
    assign wbits[p]   = NBITS'(wdata_reg[p] & LANE) << base[p];
    assign rword[p]   = DW'(mem_reg >> base[p]) & LANE;
    assign wr_fire[p] = en_reg[p] & we_reg[p];

    // read stage: data held until the next read
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        rd_reg <= '0;
      end else begin
        rd_reg.valid <= en_reg[p] & ~we_reg[p];
        if (en_reg[p] & ~we_reg[p]) begin
          rd_reg.data <= rword[p];
        end
      end
    end

    if (OUT_REG) begin : g_out_reg
      brt_pkg::brt_rsp_t out_reg;
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          out_reg <= '0;
        end else begin
          out_reg <= rd_reg;
        end
      end
      assign rsp_q[p] = out_reg;
    end else begin : g_out_bypass
      assign rsp_q[p] = rd_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // array write: port b lands last, so it wins a same-bit collision
  assign mem_step = wr_fire[0] ? ((mem_reg & ~wmask[0]) | wbits[0]) : mem_reg;
  assign mem_next = wr_fire[1] ? ((mem_step & ~wmask[1]) | wbits[1]) : mem_step;

  // reset stands for configuration: the preload image is a constant,
  // and with writes held off the tile behaves as a rom
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_reg <= INIT;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign a_rsp = rsp_q[0];
  assign b_rsp = rsp_q[1];

endmodule

// ==== bench/brt_tile_props.sv ====
// port-level assertions for the block ram tile
`timescale 1ns/100ps
module brt_tile_props #(
  parameter brt_pkg::brt_mode_t MODE    = brt_pkg::BRT_SINGLE,
  parameter bit                 OUT_REG = 1'b0
) (
  input wire logic                     core_clk,
  input wire logic                     sys_rst,
  input wire brt_pkg::brt_req_t        a_req,
  input wire brt_pkg::brt_req_t        b_req,
  input wire brt_pkg::brt_rsp_t        a_rsp,
  input wire brt_pkg::brt_rsp_t        b_rsp,
  input wire brt_pkg::brt_fifo_flags_t fifo_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire fifo = MODE == brt_pkg::BRT_FIFO;
  wire push = fifo && a_req.en && a_req.we;
  // below 256 every shape is in range
  wire a_rd = !fifo && MODE != brt_pkg::BRT_PSEUDO_DUAL && a_req.en && !a_req.we && a_req.addr < 13'h0100;
  wire b_rd = !fifo && MODE == brt_pkg::BRT_TRUE_DUAL && b_req.en && !b_req.we && b_req.addr < 13'h0100;
  wire flags_idle = fifo_flags.empty && !fifo_flags.full;
  a_read_fast: assert property (!OUT_REG && a_rd |-> ##2 a_rsp.valid) else $error("port a read late");
  a_b_read: assert property (!OUT_REG && b_rd |-> ##2 b_rsp.valid) else $error("port b read late");
  a_valid_cause: assert property (a_rsp.valid |-> (OUT_REG ? $past(a_req.en, 3) : $past(a_req.en, 2)))
    else $error("port a data without request");
  a_pop_latency: assert property (fifo && OUT_REG && b_req.en && !fifo_flags.empty |-> ##3 b_rsp.valid)
    else $error("pop data late");
  a_pop_empty: assert property (fifo && OUT_REG && b_req.en && fifo_flags.empty |-> ##3 !b_rsp.valid)
    else $error("pop from empty answered");
  a_flags_apart: assert property (!(fifo_flags.full && fifo_flags.empty)) else $error("full and empty");
  a_push_fills: assert property (fifo_flags.empty && push |=> !fifo_flags.empty) else $error("push lost");
  a_full_holds: assert property (fifo && fifo_flags.full && !b_req.en |=> fifo_flags.full)
    else $error("full dropped");
  a_reset_clean: assert property ($fell(sys_rst) |-> a_rsp == '0 && b_rsp == '0 && flags_idle)
    else $error("outputs not clean after reset");
  a_write_port_quiet: assert property (MODE == brt_pkg::BRT_PSEUDO_DUAL |-> !a_rsp.valid)
    else $error("write-only port answered");
  a_unused_port_quiet: assert property (MODE == brt_pkg::BRT_SINGLE |-> !b_rsp.valid)
    else $error("unused port answered");
  cover property (a_rsp.valid);
  cover property (fifo_flags.full);
  cover property (fifo && b_rsp.valid);
endmodule
bind brt_block_ram_tile brt_tile_props #(.MODE(MODE), .OUT_REG(OUT_REG)) u_brt_tile_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .a_req(a_req), .b_req(b_req), .a_rsp(a_rsp), .b_rsp(b_rsp), .fifo_flags(fifo_flags));

// ==== bench/brt_fabric_user.sv ====
// fabric-side requester driving one port of the tile
`timescale 1ns/100ps
module brt_fabric_user (
  input  wire logic         core_clk,
  output brt_pkg::brt_req_t req
);
  initial req = '0;
  // controls move after a falling edge and hold a full cycle
  task automatic issue(input logic we, input logic [12:0] ad, input logic [35:0] wd);
    @(negedge core_clk);
    req <= '{1'b1, we, ad, wd};
  endtask
  // write off, released lines flipped so stale values are useless
  task automatic idle();
    @(negedge core_clk);
    req <= '{1'b0, 1'b0, ~req.addr, ~req.wdata};
  endtask
endmodule

// ==== bench/brt_block_ram_tile_tb.sv ====
// self-checking bench for the block ram tile
`timescale 1ns/100ps
module brt_block_ram_tile_tb;
  localparam logic [9215:0] INIT_PAT = {288{32'h5a3c96e1}};
  logic                     core_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  brt_pkg::brt_req_t        ra, rb, fa, fb, pa, pb, sq;
  brt_pkg::brt_rsp_t        sa, sb, fs, fsa, psa, psb, ssa, ssb;
  brt_pkg::brt_fifo_flags_t fl, tf, pf, sf;
  logic [9215:0]            ref_bits = INIT_PAT;
  logic [9215:0]            pdp_bits = INIT_PAT;
  logic [9215:0]            sp_bits = INIT_PAT;
  logic [35:0]              qa[$], qb[$], qf[$], qp[$], qs[$];
  logic [35:0]              d;
  int                       seed = 32'hc11d;
  int                       miscompares = 0;
  int                       checked = 0;
  int                       cycles = 0;
  always #5 core_clk = ~core_clk;
  brt_fabric_user fab_a (.core_clk(core_clk), .req(ra));
  brt_fabric_user fab_b (.core_clk(core_clk), .req(rb));
  brt_fabric_user fifo_a (.core_clk(core_clk), .req(fa));
  brt_fabric_user fifo_b (.core_clk(core_clk), .req(fb));
  brt_fabric_user pd_a (.core_clk(core_clk), .req(pa));
  brt_fabric_user pd_b (.core_clk(core_clk), .req(pb));
  brt_fabric_user sp_a (.core_clk(core_clk), .req(sq));
  brt_block_ram_tile #(.MODE(brt_pkg::BRT_TRUE_DUAL), .WIDTH_A(4), .WIDTH_B(18), .INIT(INIT_PAT))
    u_brt_block_ram_tile (.core_clk(core_clk), .sys_rst(sys_rst), .a_req(ra), .b_req(rb), .a_rsp(sa),
    .b_rsp(sb), .fifo_flags(tf));
  brt_block_ram_tile #(.MODE(brt_pkg::BRT_FIFO), .OUT_REG(1'b1)) u_brt_block_ram_tile_fifo (.core_clk(core_clk),
    .sys_rst(sys_rst), .a_req(fa), .b_req(fb), .a_rsp(fsa), .b_rsp(fs), .fifo_flags(fl));
  // port a writes 36 wide, port b reads 9 wide over the same bits
  brt_block_ram_tile #(.MODE(brt_pkg::BRT_PSEUDO_DUAL), .WIDTH_A(36), .WIDTH_B(9), .OUT_REG(1'b1), .INIT(INIT_PAT))
    u_brt_block_ram_tile_pdp (.core_clk(core_clk), .sys_rst(sys_rst), .a_req(pa), .b_req(pb), .a_rsp(psa),
    .b_rsp(psb), .fifo_flags(pf));
  // port b shares the true dual-port driver and must stay silent
  brt_block_ram_tile #(.MODE(brt_pkg::BRT_SINGLE), .WIDTH_A(1), .INIT(INIT_PAT)) u_brt_block_ram_tile_sp (
    .core_clk(core_clk), .sys_rst(sys_rst), .a_req(sq), .b_req(rb), .a_rsp(ssa), .b_rsp(ssb), .fifo_flags(sf));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // 2048 nibbles deep on port a: past that nothing may answer
  task automatic rd_a(input int k);
    fab_a.issue(1'b0, 13'(k), 36'h0);
    if (k < 2048) qa.push_back(36'(ref_bits[k*4+:4]));
  endtask
  task automatic rd_b(input int k);
    fab_b.issue(1'b0, 13'(k), 36'h0);
    qb.push_back(36'(ref_bits[k*18+:18]));
  endtask
  ////////////////////////////////////////////////////////////////
  // unsolicited data meets an unknown note and fails
  always @(negedge core_clk) begin
    if (sa.valid === 1'b1) check("port a", sa.data, qa.size() ? qa.pop_front() : 'x);
    if (sb.valid === 1'b1) check("port b", sb.data, qb.size() ? qb.pop_front() : 'x);
    if (fs.valid === 1'b1) check("pop", fs.data, qf.size() ? qf.pop_front() : 'x);
    if (psb.valid === 1'b1) check("pseudo b", psb.data, qp.size() ? qp.pop_front() : 'x);
    if (ssa.valid === 1'b1) check("single a", ssa.data, qs.size() ? qs.pop_front() : 'x);
    check("silent ports", 36'({psa.valid, ssb.valid, fsa.valid}), 36'h0);
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 1'b0;
    for (int k = 0; k < 4; k++) rd_b(k);
    fab_b.idle();
    for (int k = 2046; k < 2049; k++) rd_a(k);
    fab_a.idle();
    for (int k = 0; k < 9; k++) begin
      d = 36'($random(seed)) & 36'hf;
      ref_bits[k*4+:4] = d[3:0];
      fab_a.issue(1'b1, 13'(k), d);
    end
    fab_a.idle();
    for (int k = 0; k < 2; k++) rd_b(k);
    d = 36'($random(seed)) & 36'h3ffff;
    ref_bits[90+:18] = d[17:0];
    fab_b.issue(1'b1, 13'h0005, d);
    fab_b.idle();
    for (int k = 22; k < 28; k++) rd_a(k);
    fab_a.idle();
    // a read on the write-only port must neither answer nor write
    pd_a.issue(1'b0, 13'h0001, 36'h0);
    d = {32'($random(seed)), 4'h5};
    pdp_bits[36+:36] = d;
    pd_a.issue(1'b1, 13'h0001, d);
    pd_a.idle();
    // write strobe on the read-only port still reads
    pd_b.issue(1'b1, 13'h0004, 36'h1ff);
    qp.push_back(36'(pdp_bits[36+:9]));
    for (int k = 3; k < 9; k++) begin
      pd_b.issue(1'b0, 13'(k), 36'h0);
      qp.push_back(36'(pdp_bits[k*9+:9]));
    end
    pd_b.idle();
    sp_a.issue(1'b0, 13'h1fff, 36'h0);
    qs.push_back(36'(sp_bits[8191]));
    d = 36'($random(seed));
    sp_bits[7] = d[0];
    sp_a.issue(1'b1, 13'h0007, d);
    for (int k = 6; k < 9; k++) begin
      sp_a.issue(1'b0, 13'(k), 36'h0);
      qs.push_back(36'(sp_bits[k]));
    end
    sp_a.idle();
    for (int k = 0; k < 1024; k++) begin
      d = 36'($random(seed)) & 36'h1ff;
      qf.push_back(d);
      fifo_a.issue(1'b1, 13'h0000, d);
    end
    fifo_a.idle();
    @(negedge core_clk) check("full", 36'(fl.full), 36'h1);
    fifo_a.issue(1'b1, 13'h0000, 36'h0ab);
    fifo_a.idle();
    repeat (1024) fifo_b.issue(1'b0, 13'h0000, 36'h0);
    fifo_b.idle();
    fifo_b.issue(1'b0, 13'h0000, 36'h0);
    fifo_b.idle();
    repeat (8) @(negedge core_clk);
    check("empty", 36'(fl.empty), 36'h1);
    check("left", 36'(qa.size() + qb.size() + qf.size() + qp.size() + qs.size()), 36'h0);
    check("idle flags", 36'({tf, pf, sf}), 36'h15);
    report_and_stop();
  end
endmodule
